// File: tsw_pkg.sv
/*
  Shared constants and types for the time-slot switch stream side and its test port.
  Assumes one 40 MHz system clock and that every pin input is already synchronous to it.
*/
package tsw_pkg;

  // ----------------------------------------------------------------
  // Sizes and rates
  // ----------------------------------------------------------------
  localparam int STREAMS = 16;
  localparam int CHANNELS = 128;
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [10:0] FBITS_2M = 11'h100;
  localparam logic [10:0] FBITS_4M = 11'h200;
  localparam logic [10:0] FBITS_8M = 11'h400;
  localparam int FIRST_FLOAT_STREAM = 8;
  localparam logic [3:0] FP_IDLE_SAMPLES = 4'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int MCLK_NS = 25;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + MCLK_NS - 1) / MCLK_NS;

  // ----------------------------------------------------------------
  // Test access port
  // ----------------------------------------------------------------
  localparam logic [1:0] IR_BYPASS = 2'h3;
  localparam logic [1:0] IR_CAPTURE = 2'h1;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SHIFT_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SHIFT_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PAUSE_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } tap_state_e;

  typedef struct packed {
    logic tck_q;
    tap_state_e st;
    logic [1:0] ir;
    logic [1:0] ir_sh;
    logic dr_sh;
    logic tdo;
    logic tdo_oe;
  } tap_regs_s;

  // One connection memory entry: float, message mode, source stream and channel.
  typedef struct packed {
    logic hiz;
    logic msg;
    logic [3:0] src_strm;
    logic [6:0] src_ch;
  } conn_s;

  typedef struct packed {
    logic sclk_q;
    logic half;
    logic fp_prev;
    logic fp_idle;
    logic [3:0] fp_run;
    logic gci;
    logic framed;
    logic [9:0] pos;
    logic [15:0][2:0] offs;
    logic [15:0][6:0] in_sh;
    logic [15:0][7:0] out_sh;
    logic [15:0] hiz;
    logic [15:0] oe;
    logic fe_prev;
    logic eval_run;
    logic [10:0] eval_cnt;
    logic [10:0] eval_count;
    logic eval_done;
  } sw_regs_s;

endpackage

// File: tsw_tap.sv
/*
  Boundary-scan test access port controller with a bypass data path.
  Assumes test pins are synchronous to mclk and that undriven pins are pulled up outside.
*/
module tsw_tap
  import tsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic trst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe
);

  tap_regs_s tap_ff;
  tap_regs_s nxt_tap;
  logic tck_rise;
  logic tck_fall;
  logic in_shift;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Test clock edges are found by sampling, so tck must stay well below mclk.
  always_comb
  begin
    nxt_tap = tap_ff;
    tck_rise = tck && !tap_ff.tck_q;
    tck_fall = !tck && tap_ff.tck_q;
    in_shift = (tap_ff.st == TAP_SHIFT_DR) || (tap_ff.st == TAP_SHIFT_IR);
    nxt_tap.tck_q = tck;
    if (tck_rise)
    begin
      case (tap_ff.st)
        TAP_RESET: nxt_tap.st = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: nxt_tap.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: nxt_tap.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: nxt_tap.st = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: nxt_tap.st = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
        TAP_EX1_DR: nxt_tap.st = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: nxt_tap.st = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
        TAP_EX2_DR: nxt_tap.st = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: nxt_tap.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: nxt_tap.st = tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: nxt_tap.st = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: nxt_tap.st = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
        TAP_EX1_IR: nxt_tap.st = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: nxt_tap.st = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
        TAP_EX2_IR: nxt_tap.st = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: nxt_tap.st = tms ? TAP_SEL_DR : TAP_IDLE;
        default: nxt_tap.st = TAP_RESET;
      endcase
      case (tap_ff.st)
        TAP_RESET: nxt_tap.ir = IR_BYPASS;
        TAP_CAP_DR: nxt_tap.dr_sh = 1'b0;
        TAP_SHIFT_DR: nxt_tap.dr_sh = tdi;
        TAP_CAP_IR: nxt_tap.ir_sh = IR_CAPTURE;
        TAP_SHIFT_IR: nxt_tap.ir_sh = {tdi, tap_ff.ir_sh[1]};
        TAP_UPD_IR: nxt_tap.ir = tap_ff.ir_sh;
        default: nxt_tap.ir = tap_ff.ir;
      endcase
    end
    // Output moves only on the falling test clock edge and floats outside shifts.
    if (tck_fall)
    begin
      nxt_tap.tdo = (tap_ff.st == TAP_SHIFT_IR) ? tap_ff.ir_sh[0] : tap_ff.dr_sh;
      nxt_tap.tdo_oe = in_shift;
    end
  end

  // Test reset acts without any clock edge, as does the device reset.
  always_ff @(posedge mclk or negedge rst_b or negedge trst_b)
  begin
    if (!rst_b || !trst_b)
    begin
      // The sampled test clock resets high, like its pulled-up pin, so no false edge follows.
      tap_ff <= '{tck_q: 1'b1, st: TAP_RESET, ir: IR_BYPASS, ir_sh: 2'h0,
                  dr_sh: 1'b0, tdo: 1'b0, tdo_oe: 1'b0};
    end
    else
    begin
      tap_ff <= nxt_tap;
    end
  end

  assign tdo = tap_ff.tdo;
  assign tdo_oe = tap_ff.tdo_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tdo_falling: assert property (@(posedge mclk) disable iff (!rst_b || !trst_b)
    !(!tck && tap_ff.tck_q) |=> $stable(tdo))
    else $error("Test data output moved without a falling test clock.");

  chk_tdo_float: assert property (@(posedge mclk) disable iff (!rst_b || !trst_b)
    (!tck && tap_ff.tck_q && !in_shift) |=> !tdo_oe)
    else $error("Test data output driven outside a shift state.");

endmodule

// File: tsw_switch.sv
/*
  Stream side of a sixteen by sixteen non-blocking time-slot switch with a test port.
  Assumes all pins are synchronous to the 40 MHz mclk and that the serial clock,
  at twice the bit rate, is slow enough to be edge-detected by sampling.
*/
module tsw_switch
  import tsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic frame_pulse_in,
  input wire logic frame_eval_or_aux_clock,
  input wire logic wide_frame_select,
  input wire logic [1:0] rate_select_field,
  input wire logic internal_tie_pin,
  input wire logic [15:0] serial_in_streams,
  output logic [15:0] serial_out_streams,
  output logic [15:0] serial_out_oe,
  input wire logic conn_wr,
  input wire logic [3:0] conn_strm,
  input wire logic [6:0] conn_ch,
  input wire conn_s conn_data,
  input wire logic offset_wr,
  input wire logic [3:0] offset_strm,
  input wire logic [2:0] offset_bits,
  output logic [10:0] eval_count,
  output logic eval_done,
  output logic gci_format,
  input wire logic trst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bits in one 125 us frame: eight bits per 64 kb/s channel.
  function automatic logic [10:0] frame_bits(input logic [1:0] rate);
    case (rate)
      RATE_4M: frame_bits = FBITS_4M;
      RATE_8M: frame_bits = FBITS_8M;
      default: frame_bits = FBITS_2M;
    endcase
  endfunction

  // Bit position of a stream delayed by its offset, wrapped inside the frame.
  function automatic logic [9:0] wrap_sub(input logic [9:0] pos, input logic [2:0] off,
                                          input logic [10:0] fbits);
    logic [10:0] sum;
    sum = {1'b0, pos} + fbits - {8'h00, off};
    if (sum >= fbits)
    begin
      sum = sum - fbits;
    end
    wrap_sub = sum[9:0];
  endfunction

  sw_regs_s sw_ff;
  sw_regs_s nxt_sw;
  logic [7:0] data_mem [STREAMS][CHANNELS];
  conn_s conn_mem [STREAMS][CHANNELS];
  logic [15:0] dm_we;
  logic [15:0][6:0] dm_ch;
  logic [15:0][7:0] dm_byte;
  logic sclk_fall;
  logic fp_now;
  logic frame_start;
  logic boundary;
  logic mid_bit;
  logic [10:0] fbits;
  logic [9:0] pos_next;
  logic [9:0] spos;
  logic fe_fall;
  conn_s entry;

  // ----------------------------------------------------------------
  // Frame timing and stream datapath
  // ----------------------------------------------------------------
  // Everything advances on falling serial clock edges; two edges make one bit.
  always_comb
  begin
    nxt_sw = sw_ff;
    dm_we = '0;
    dm_ch = '0;
    dm_byte = '0;
    entry = '0;
    spos = '0;
    fbits = frame_bits(rate_select_field);
    sclk_fall = !serial_clk && sw_ff.sclk_q;
    fp_now = frame_pulse_in;
    frame_start = 1'b0;
    boundary = 1'b0;
    mid_bit = 1'b0;
    pos_next = sw_ff.pos;
    fe_fall = 1'b0;
    nxt_sw.sclk_q = serial_clk;
    if (offset_wr)
    begin
      nxt_sw.offs[offset_strm] = offset_bits;
    end
    if (sclk_fall)
    begin
      nxt_sw.fp_prev = fp_now;
      if (wide_frame_select)
      begin
        // Wide pulse: falling edge of the low pulse, aligned to a high auxiliary clock.
        frame_start = sw_ff.fp_prev && !fp_now && frame_eval_or_aux_clock;
      end
      else
      begin
        // The level that persists is the idle level; a departure from it is the pulse.
        if (fp_now == sw_ff.fp_prev)
        begin
          if (sw_ff.fp_run != FP_IDLE_SAMPLES)
          begin
            nxt_sw.fp_run = sw_ff.fp_run + 4'h1;
          end
          else
          begin
            nxt_sw.fp_idle = fp_now;
            nxt_sw.gci = !fp_now;
          end
        end
        else
        begin
          nxt_sw.fp_run = '0;
        end
        frame_start = (fp_now != sw_ff.fp_idle) && (sw_ff.fp_prev == sw_ff.fp_idle);
      end
      if (frame_start)
      begin
        boundary = 1'b1;
        nxt_sw.half = 1'b0;
        nxt_sw.framed = 1'b1;
        pos_next = '0;
      end
      else
      begin
        nxt_sw.half = !sw_ff.half;
        boundary = sw_ff.half;
        mid_bit = !sw_ff.half;
        if (sw_ff.half)
        begin
          pos_next = ({1'b0, sw_ff.pos} + 11'h001 >= fbits) ? 10'h000 : sw_ff.pos + 10'h001;
        end
      end
      nxt_sw.pos = pos_next;
    end
    // Inputs are sampled mid-bit, each stream on its own delayed bit count.
    if (mid_bit && sw_ff.framed)
    begin
      for (int s = 0; s < STREAMS; s++)
      begin
        spos = wrap_sub(sw_ff.pos, sw_ff.offs[s], fbits);
        nxt_sw.in_sh[s] = {sw_ff.in_sh[s][5:0], serial_in_streams[s]};
        if (spos[2:0] == LAST_BIT)
        begin
          dm_we[s] = 1'b1;
          dm_ch[s] = spos[9:3];
          dm_byte[s] = {sw_ff.in_sh[s], serial_in_streams[s]};
        end
      end
    end
    // Each output fetches its next byte from any stream and channel at a channel start.
    if (boundary)
    begin
      for (int o = 0; o < STREAMS; o++)
      begin
        if (pos_next[2:0] == 3'h0)
        begin
          entry = conn_mem[o][pos_next[9:3]];
          nxt_sw.out_sh[o] = entry.msg ? {entry.src_strm[0], entry.src_ch}
                                       : data_mem[entry.src_strm][entry.src_ch];
          nxt_sw.hiz[o] = entry.hiz;
        end
        else
        begin
          nxt_sw.out_sh[o] = {sw_ff.out_sh[o][6:0], 1'b0};
        end
      end
    end
    // Low streams drive once framed while the tie pin is low; high streams may float per channel.
    for (int o = 0; o < STREAMS; o++)
    begin
      nxt_sw.oe[o] = nxt_sw.framed && !internal_tie_pin
                     && ((o < FIRST_FLOAT_STREAM) || !nxt_sw.hiz[o]);
    end
    // Offset measurement: half-bits from frame start to the evaluation pin falling.
    if (sclk_fall && !wide_frame_select)
    begin
      nxt_sw.fe_prev = frame_eval_or_aux_clock;
      fe_fall = sw_ff.fe_prev && !frame_eval_or_aux_clock;
      if (frame_start)
      begin
        nxt_sw.eval_run = 1'b1;
        nxt_sw.eval_cnt = '0;
      end
      else if (sw_ff.eval_run && fe_fall)
      begin
        nxt_sw.eval_run = 1'b0;
        nxt_sw.eval_count = sw_ff.eval_cnt;
        nxt_sw.eval_done = 1'b1;
      end
      else if (sw_ff.eval_run)
      begin
        nxt_sw.eval_cnt = sw_ff.eval_cnt + 11'h001;
      end
    end
  end

  // Reset clears all control state and floats every stream output.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_ff <= '0;
    end
    else
    begin
      sw_ff <= nxt_sw;
    end
  end

  // Memories carry no reset; a channel reads stale data until first written.
  always_ff @(posedge mclk)
  begin
    for (int s = 0; s < STREAMS; s++)
    begin
      if (dm_we[s])
      begin
        data_mem[s][dm_ch[s]] <= dm_byte[s];
      end
    end
    if (conn_wr)
    begin
      conn_mem[conn_strm][conn_ch] <= conn_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output bit is the register bit that holds it.
  always_comb
  begin
    for (int o = 0; o < STREAMS; o++)
    begin
      serial_out_streams[o] = sw_ff.out_sh[o][7];
    end
  end

  assign serial_out_oe = sw_ff.oe;
  assign eval_count = sw_ff.eval_count;
  assign eval_done = sw_ff.eval_done;
  assign gci_format = sw_ff.gci;

  tsw_tap u_tap (
    .mclk(mclk),
    .rst_b(rst_b),
    .trst_b(trst_b),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start_edge;
    sclk_fall && frame_start;
  endsequence

  sequence s_pos_cleared;
    (sw_ff.pos == 10'h000) && !sw_ff.half && sw_ff.framed;
  endsequence

  chk_start_clears_pos: assert property (@(posedge mclk) disable iff (!rst_b)
    s_start_edge |=> s_pos_cleared)
    else $error("Frame start did not clear the bit position.");

  chk_pos_in_frame: assert property (@(posedge mclk) disable iff (!rst_b)
    $stable(rate_select_field) |-> ({1'b0, sw_ff.pos} < frame_bits(rate_select_field)))
    else $error("Bit position beyond the frame length.");

  chk_unframed_float: assert property (@(posedge mclk) disable iff (!rst_b)
    !sw_ff.framed |-> (serial_out_oe == 16'h0000))
    else $error("Stream output driven before the first frame.");

  chk_low_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    (sw_ff.framed && !internal_tie_pin) |=> (serial_out_oe[7:0] == 8'hff))
    else $error("A low stream output floated while framed.");

  chk_tie_float: assert property (@(posedge mclk) disable iff (!rst_b)
    internal_tie_pin |=> (serial_out_oe == 16'h0000))
    else $error("Outputs driven with the tie pin high.");

  chk_out_shift: assert property (@(posedge mclk) disable iff (!rst_b)
    (boundary && pos_next[2:0] != 3'h0) |=> (serial_out_streams[0] == $past(sw_ff.out_sh[0][6]))
      && (sw_ff.out_sh[0] == {$past(sw_ff.out_sh[0][6:0]), 1'b0}))
    else $error("Output stream did not shift one bit at a bit boundary.");

  chk_eval_capture: assert property (@(posedge mclk) disable iff (!rst_b)
    (sclk_fall && !wide_frame_select && sw_ff.eval_run && fe_fall && !frame_start)
      |=> eval_done && (eval_count == $past(sw_ff.eval_cnt)) ##1 !sw_ff.eval_run)
    else $error("Evaluation count not captured on the evaluation pin edge.");

  chk_wide_no_aux: assert property (@(posedge mclk) disable iff (!rst_b)
    (wide_frame_select && sclk_fall && !frame_eval_or_aux_clock) |-> !frame_start)
    else $error("Wide frame start taken without the auxiliary clock high.");

endmodule

// File: tsw_stream_partner.sv
/*
  Far-side model of a TDM sender and receiver for the switch stream pins.
  Assumes mclk at 40 MHz and rate code 0: one serial clock lasts 8 mclk, 256 bits a frame.
*/
module tsw_stream_partner
  import tsw_pkg::*;
(
  input wire logic mclk,
  input wire logic run,
  input wire logic fp_idle,
  input wire logic [15:0] serial_out_streams,
  input wire logic [15:0] serial_out_oe,
  output logic serial_clk,
  output logic aux_clk,
  output logic frame_pulse_in,
  output logic [15:0] serial_in_streams
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  logic [8:0] sc;
  int fcnt;
  logic [15:0] ibits [0:255];
  logic [2:0] obits [0:1023];

  // ----------------------------------------------------------------
  // Sender and recorder
  // ----------------------------------------------------------------
  // Counters are cleared while stopped, so every run starts on a frame boundary.
  initial
  begin
    ph = 3'h0;
    sc = 9'h0;
    fcnt = 0;
    serial_clk = 1'b1;
    aux_clk = 1'b1;
    frame_pulse_in = 1'b1;
    serial_in_streams = 16'h0;
    foreach (ibits[i]) ibits[i] = 16'h0;
  end

  // Bits change mid-clock so each is settled at the sampling fall; the clock stands still when stopped.
  always @(negedge mclk)
  begin
    if (run)
    begin
      ph <= ph + 3'h1;
      if (ph == 3'h0)
      begin
        serial_clk <= 1'b1;
        aux_clk <= 1'b0;
        frame_pulse_in <= (sc == 9'h0) ? ~fp_idle : fp_idle;
        if (sc[0])
          serial_in_streams <= ibits[sc[8:1]];
      end
      // The auxiliary clock runs opposite the serial clock, so it is high at each sampled fall.
      if (ph == 3'h4)
      begin
        serial_clk <= 1'b0;
        aux_clk <= 1'b1;
        if (sc[0] && fcnt < 4)
          obits[fcnt * 256 + sc[8:1]] <= {serial_out_oe[8], serial_out_streams[1:0]};
      end
      if (ph == 3'h7)
      begin
        sc <= sc + 9'h1;
        if (sc == 9'h1ff)
          fcnt <= fcnt + 1;
      end
    end
    else
    begin
      ph <= 3'h0;
      sc <= 9'h0;
      fcnt <= 0;
      serial_clk <= 1'b1;
      aux_clk <= 1'b1;
      frame_pulse_in <= fp_idle;
      serial_in_streams <= ~serial_in_streams; // Released lines never hold a stale value.
    end
  end
endmodule

// File: test_tsw_switch.sv
/*
  Self-checking bench for the switch stream pins and test port.
  Assumes the stream partner model beside it and a 40 MHz mclk.
*/
module test_tsw_switch
  import tsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, run, fp_idle, serial_clk, frame_pulse_in, frame_eval_or_aux_clock;
  logic wide_frame_select, internal_tie_pin, conn_wr, offset_wr, eval_done, gci_format;
  logic trst_b, tck, tms, tdi, tdo, tdo_oe, aux_clk;
  logic [1:0] rate_select_field;
  logic [15:0] serial_in_streams, serial_out_streams, serial_out_oe;
  logic [3:0] conn_strm, offset_strm;
  logic [6:0] conn_ch;
  logic [2:0] offset_bits;
  logic [10:0] eval_count;
  conn_s conn_data;
  int fail_count, check_count;

  // In wide mode the pin carries the partner's auxiliary clock, gated by the bench's pin level.
  tsw_switch tsw_switch_inst (.mclk, .rst_b, .serial_clk, .frame_pulse_in,
    .frame_eval_or_aux_clock(wide_frame_select ? (aux_clk && frame_eval_or_aux_clock)
                                               : frame_eval_or_aux_clock),
    .wide_frame_select, .rate_select_field, .internal_tie_pin,
    .serial_in_streams, .serial_out_streams, .serial_out_oe, .conn_wr, .conn_strm, .conn_ch,
    .conn_data, .offset_wr, .offset_strm, .offset_bits, .eval_count, .eval_done,
    .gci_format, .trst_b, .tck, .tms, .tdi, .tdo, .tdo_oe);

  tsw_stream_partner tsw_stream_partner_inst (.mclk, .run, .fp_idle, .serial_out_streams,
    .serial_out_oe, .serial_clk, .aux_clk, .frame_pulse_in, .serial_in_streams);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Clock at 25 ns.
  always #12.5 mclk = ~mclk;

  task automatic check_val(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Rebuilds one recorded channel byte, first bit on the wire in the top position.
  function automatic logic [7:0] get_byte(input int f, input int c, input int lane);
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
      b[7 - i] = tsw_stream_partner_inst.obits[f * 256 + c * 8 + i][lane];
    return b;
  endfunction

  // Back-to-back calls keep the strobe high, so each call writes one word.
  task automatic conn_write(input logic [3:0] s, input logic [6:0] c, input conn_s d);
    conn_wr = 1'b1;
    conn_strm = s;
    conn_ch = c;
    conn_data = d;
    @(negedge mclk);
  endtask

  task automatic wait_frame(input int n);
    for (int i = 0; i < 20000 && tsw_stream_partner_inst.fcnt < n; i++)
      @(negedge mclk);
  endtask

  // Five cycles low is 125 ns, above the minimum.
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
  endtask

  // One test clock: low for 4 mclk, then high for 4 mclk; the output must hold while high.
  task automatic tap_step(input logic m, output logic [1:0] s);
    tms = m;
    tck = 1'b0;
    repeat (4) @(negedge mclk);
    s = {tdo_oe, tdo};
    tck = 1'b1;
    repeat (4) @(negedge mclk);
    check_val("tdo hold", {tdo_oe, tdo}, s);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check_val("oe after reset", serial_out_oe, 16'h0);
    check_val("tdo_oe after reset", tdo_oe, 16'h0);
    check_val("eval_done after reset", eval_done, 16'h0);
    $display("test reset done");
  endtask

  // Message, switched, delayed and floated channels across whole frames of standard framing.
  task automatic t_frames();
    logic [7:0] v;
    v = 8'h5c;
    // Stream 0 carries a message byte in every channel, so its shifter never holds unknowns.
    for (int c = 0; c < CHANNELS; c++)
      conn_write(4'h0, c[6:0], '{1'b0, 1'b1, 4'h0, c[6:0]});
    conn_write(4'h0, 7'h00, '{1'b0, 1'b1, 4'h1, 7'h25});
    conn_write(4'h1, 7'h05, '{1'b0, 1'b0, 4'h3, 7'h02});
    conn_write(4'h8, 7'h00, '{1'b1, 1'b0, 4'h0, 7'h00});
    conn_write(4'h8, 7'h01, '{1'b0, 1'b1, 4'h0, 7'h3c});
    conn_wr = 1'b0;
    // Stream 3 is delayed by one bit, so its channel 2 byte occupies bits 17 to 24.
    offset_strm = 4'h3;
    offset_bits = 3'h1;
    offset_wr = 1'b1;
    @(negedge mclk);
    offset_wr = 1'b0;
    for (int i = 0; i < 8; i++)
      tsw_stream_partner_inst.ibits[17 + i][3] = v[7 - i];
    run = 1'b1;
    wait_frame(1);
    // The pin falls at the twelfth serial fall after the frame start, when the count is 11.
    repeat (100) @(negedge mclk);
    frame_eval_or_aux_clock = 1'b0;
    wait_frame(3);
    check_val("message byte", get_byte(2, 0, 0), 16'h00a5);
    check_val("switched byte", get_byte(2, 5, 1), 16'h005c);
    check_val("floated oe", get_byte(2, 0, 2), 16'h0000);
    check_val("driven oe", get_byte(2, 1, 2), 16'h00ff);
    check_val("gci standard", gci_format, 16'h0);
    check_val("eval done", eval_done, 16'h1);
    check_val("eval count", eval_count, 16'h000b);
    $display("test frames done");
  endtask

  // The tie pin high floats every stream even while framed.
  task automatic t_tie();
    internal_tie_pin = 1'b1;
    repeat (3) @(negedge mclk);
    check_val("oe tie high", serial_out_oe, 16'h0);
    internal_tie_pin = 1'b0;
    $display("test tie done");
  endtask

  // Mid-run reset, then the idle-low pulse format must be found on its own.
  task automatic t_gci();
    run = 1'b0;
    fp_idle = 1'b0;
    do_reset();
    check_val("oe mid reset", serial_out_oe, 16'h0);
    conn_write(4'h0, 7'h00, '{1'b0, 1'b1, 4'h1, 7'h25});
    conn_wr = 1'b0;
    run = 1'b1;
    wait_frame(2);
    check_val("gci message", get_byte(1, 0, 0), 16'h00a5);
    check_val("gci found", gci_format, 16'h1);
    $display("test gci done");
  endtask

  // Wide active-low pulses: no frame is taken until the auxiliary clock is let through.
  task automatic t_wide();
    run = 1'b0;
    fp_idle = 1'b1;
    wide_frame_select = 1'b1;
    do_reset();
    run = 1'b1;
    wait_frame(2);
    check_val("oe without aux clock", serial_out_oe, 16'h0);
    frame_eval_or_aux_clock = 1'b1;
    wait_frame(3);
    check_val("wide message", get_byte(2, 0, 0), 16'h00a5);
    $display("test wide done");
  endtask

  // Walks into instruction shift; capture 01 comes out low bit first.
  task automatic t_tap();
    logic [8:0] pat;
    logic [1:0] s;
    pat = 9'h0c6;
    for (int k = 0; k < 9; k++)
    begin
      tap_step(pat[k], s);
      check_val("tdo_oe", s[1], (k == 5 || k == 6));
      if (k == 5 || k == 6)
        check_val("tdo", s[0], (k == 5));
    end
    pat = 9'h003;
    for (int k = 0; k < 5; k++)
      tap_step(pat[k], s);
    check_val("tdo_oe shifting", s[1], 16'h1);
    trst_b = 1'b0;
    #5;
    check_val("tdo_oe test reset", tdo_oe, 16'h0);
    @(negedge mclk);
    trst_b = 1'b1;
    tap_step(1'b0, s);
    check_val("tdo_oe after test reset", s[1], 16'h0);
    $display("test tap done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  // Test pins start high as the pull-ups would leave them; test reset is pulsed at power-up.
  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    trst_b = 1'b0;
    {run, wide_frame_select, internal_tie_pin, conn_wr, offset_wr} = 5'h0;
    {fp_idle, frame_eval_or_aux_clock} = 2'h3;
    {tck, tms, tdi} = 3'h7;
    rate_select_field = RATE_2M;
    {conn_strm, conn_ch, offset_strm, offset_bits} = 18'h0;
    conn_data = '0;
    fail_count = 0;
    check_count = 0;
    do_reset();
    trst_b = 1'b1;
    t_reset();
    t_frames();
    t_tie();
    t_gci();
    t_wide();
    t_tap();
    end_sim();
  end

  // The full run needs about 0.85 ms; a hang past 2 ms counts as a mismatch.
  initial
  begin
    #2ms;
    fail_count++;
    end_sim();
  end
endmodule
